// >>> rtl/ge_compare_pkg.sv
// constants and carrier types for the scalable greater-or-equal comparator
package ge_compare_pkg;

  // global timer and comparator datapath width
  localparam int unsigned TIMER_W      = 24;
  // difference width: timer width plus the sign (borrow) bit
  localparam int unsigned DIFF_W       = TIMER_W + 1;
  // width of the scale select field
  localparam int unsigned SCALE_W      = 4;
  // number of selectable difference bits: sign bit plus fifteen upper bits
  localparam int unsigned SEL_COUNT    = 16;
  // lowest result bit reachable by a signed setting
  localparam int unsigned SIGNED_BASE  = 9;
  // highest signed scale setting
  localparam logic [3:0]  SCALE_SIGNED_MAX = 4'he;
  // scale setting that picks the sign bit (unsigned compare)
  localparam logic [3:0]  SCALE_UNSIGNED   = 4'hf;
  // shortest period that a signed setting covers
  localparam int unsigned SIGNED_MIN_PERIOD = 512;
  // reset value of the held threshold
  localparam logic [23:0] THRESHOLD_RST    = 24'h00_0000;

  // threshold transfer from a capture cell's compare register update
  typedef struct packed {
    logic        load;
    logic [23:0] value;
  } compare_update_s;

endpackage

// >>> rtl/scalable_ge_comparator.sv
// scalable signed/unsigned greater-or-equal comparator of one global timer
//
// Behaviour
// RULE1: flag source is timer minus threshold difference
// RULE2: selected difference bit drives the flag
// RULE3: operands are timer count and update threshold
// RULE4: comparator datapath is 24 bits wide
// RULE5: scale fifteen routes sign bit, unsigned compare
// RULE6: scale zero to fourteen picks upper bit
// RULE7: unsigned: sign zero After, one Before
// RULE8: signed: selected bit zero After, one Before
// RULE9: signed selected bit index is scale plus nine
// RULE10: software uses signed only above period 512
// RULE11: software keeps period within (2^k, 2^(k+1)]
// RULE12: unsigned observation window equals full period
// RULE13: signed core window is 2*(period - 2^k)
// RULE14: flag follows timer and threshold without delay
`timescale 1ns/10ps
`default_nettype none

module scalable_ge_comparator (
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic [23:0]                      timer_value_i,
  input  wire ge_compare_pkg::compare_update_s  update_i,
  input  wire logic [3:0]                       compare_scale_select_i,
  output logic                                  timer_ge_flag_o
);
  import ge_compare_pkg::*;

  logic [TIMER_W-1:0]   threshold;
  logic [TIMER_W-1:0]   next_threshold;
  logic [TIMER_W-1:0]   live_threshold;
  logic [DIFF_W-1:0]    difference;
  logic [SEL_COUNT-1:0] candidates;

  // next value of the held threshold: captured on each compare update
  always_comb begin
    next_threshold = threshold;
    if (update_i.load) begin
      next_threshold = update_i.value; // see RULE3
    end
  end

  // held threshold register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      threshold <= THRESHOLD_RST;
    end else begin
      threshold <= next_threshold;
    end
  end

  // the update cycle compares against the bus value itself, so a threshold
  // already passed is flagged at once rather than a cycle late
  assign live_threshold = update_i.load ? update_i.value : threshold; // see RULE3 see RULE14

  // two's complement difference, borrow lands in the sign bit
  assign difference = {1'b0, timer_value_i} - {1'b0, live_threshold}; // see RULE1 see RULE4

  // only the sign bit and the fifteen upper result bits are selectable
  genvar g;
  generate
    for (g = 0; g < SEL_COUNT; g++) begin : g_sel
      if (g == SEL_COUNT - 1) begin : g_sign
        assign candidates[g] = difference[DIFF_W-1]; // see RULE5 see RULE7 see RULE12
      end else begin : g_bit
        assign candidates[g] = difference[g + SIGNED_BASE]; // see RULE6 see RULE8 see RULE9
      end
    end
  endgenerate

  // flag is purely combinational on the live operands; a register here
  // would make the flag lag a fresh timer value by a clock
  assign timer_ge_flag_o = candidates[compare_scale_select_i]; // see RULE2 see RULE14

  // checks on the flag and the held threshold
  logic [TIMER_W-1:0] wrap_diff;
  logic [TIMER_W-1:0] load_diff;
  logic [TIMER_W-1:0] held_diff;
  logic [TIMER_W-1:0] span;
  logic [4:0]         pick_index;
  logic               signed_mode;
  logic               unsigned_mode;

  // helper: modular differences, picked bit index and half-window for checks;
  // five index bits, since setting fourteen plus nine needs bit 23
  assign wrap_diff     = timer_value_i - live_threshold;
  assign load_diff     = timer_value_i - update_i.value;
  assign held_diff     = timer_value_i - threshold;
  assign signed_mode   = (compare_scale_select_i <= SCALE_SIGNED_MAX);
  assign unsigned_mode = (compare_scale_select_i == SCALE_UNSIGNED);
  assign pick_index    = 5'(compare_scale_select_i) + 5'(SIGNED_BASE);
  assign span          = TIMER_W'(1) << pick_index;

  // unsigned: timer at or past the threshold is After
  unsigned_after_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE7
    (compare_scale_select_i == SCALE_UNSIGNED && timer_value_i >= live_threshold)
      |-> !timer_ge_flag_o)
    else $error("unsigned compare not After with timer at or past threshold");

  // unsigned: timer below the threshold is Before
  unsigned_before_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE12
    (compare_scale_select_i == SCALE_UNSIGNED && timer_value_i < live_threshold)
      |-> timer_ge_flag_o)
    else $error("unsigned compare not Before with timer below threshold");

  // signed: flag is result bit setting plus nine
  signed_bit_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE9
    signed_mode |-> timer_ge_flag_o == wrap_diff[pick_index])
    else $error("signed compare picked the wrong result bit");

  // signed: After half of the comparator window
  core_after_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE13
    (signed_mode && wrap_diff < span) |-> !timer_ge_flag_o)
    else $error("signed compare not After inside the After half");

  // signed: Before half of the comparator window
  core_before_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE8
    (signed_mode && wrap_diff >= (24'h00_0000 - span)) |-> timer_ge_flag_o)
    else $error("signed compare not Before inside the Before half");

  // held threshold takes each update value
  threshold_load_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE3
    update_i.load |=> threshold == $past(update_i.value))
    else $error("held threshold did not take the update value");

  // held threshold only moves on an update
  threshold_hold_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE3
    !update_i.load |=> $stable(threshold))
    else $error("held threshold changed without an update");

  // unsigned flag tracks a new timer value at once
  flag_follow_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE14
    ($changed(timer_value_i) && !update_i.load && $stable(compare_scale_select_i)
      && compare_scale_select_i == SCALE_UNSIGNED)
      |-> timer_ge_flag_o == (timer_value_i < threshold))
    else $error("flag did not follow a new timer value in the same cycle");

  // unsigned setting routes the borrow of the subtraction
  sign_source_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE5
    (compare_scale_select_i == SCALE_UNSIGNED)
      |-> timer_ge_flag_o == (live_threshold > timer_value_i))
    else $error("unsigned setting did not route the sign bit");

  // held threshold sits at its reset value while reset is applied
  threshold_reset_a : assert property (@(posedge clk_i) // see RULE3
    !rst_n_i |-> threshold == THRESHOLD_RST)
    else $error("held threshold left its reset value during reset");

  // load cycle, unsigned: the bus value is the threshold at once
  bypass_unsigned_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE14
    (update_i.load && unsigned_mode)
      |-> timer_ge_flag_o == (timer_value_i < update_i.value))
    else $error("unsigned flag ignored the threshold on its load cycle");

  // load cycle, signed: picked bit of timer minus bus value
  bypass_signed_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE14
    (update_i.load && signed_mode) |-> timer_ge_flag_o == load_diff[pick_index])
    else $error("signed flag ignored the threshold on its load cycle");

  // between loads, signed: picked bit of timer minus held threshold
  held_signed_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE3
    (!update_i.load && signed_mode) |-> timer_ge_flag_o == held_diff[pick_index])
    else $error("signed flag did not use the held threshold");

  // between loads, unsigned: Before while timer is below held threshold
  held_unsigned_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE7
    (!update_i.load && unsigned_mode) |-> timer_ge_flag_o == (timer_value_i < threshold))
    else $error("unsigned flag did not use the held threshold");

  // timer on the threshold itself is After in every mode
  equal_after_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE13
    (timer_value_i == live_threshold) |-> !timer_ge_flag_o)
    else $error("timer equal to the threshold not reported After");

  // timer one count short of a nonzero threshold is Before
  short_before_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE8
    (timer_value_i == live_threshold - 24'h00_0001 && (signed_mode || live_threshold != '0))
      |-> timer_ge_flag_o)
    else $error("timer just below the threshold not reported Before");

  // only the upper result bits count: a small lead is After
  low_bits_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE1
    (signed_mode && wrap_diff < TIMER_W'(SIGNED_MIN_PERIOD)) |-> !timer_ge_flag_o)
    else $error("signed flag reacted to a result bit below the selectable range");

  // highest signed setting picks result bit 23
  top_scale_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE9
    (compare_scale_select_i == SCALE_SIGNED_MAX)
      |-> timer_ge_flag_o == wrap_diff[TIMER_W-1])
    else $error("highest signed setting did not pick the top result bit");

  // lowest signed setting picks result bit 9
  bottom_scale_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE9
    (compare_scale_select_i == 4'h0) |-> timer_ge_flag_o == wrap_diff[SIGNED_BASE])
    else $error("lowest signed setting did not pick its result bit");

  // zero threshold in unsigned mode: whole period is After
  zero_threshold_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE12
    (unsigned_mode && live_threshold == '0) |-> !timer_ge_flag_o)
    else $error("unsigned compare against a zero threshold not After");

  // held copy agrees with the bypass: no flag step as a load ends
  load_seam_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE14
    update_i.load ##1 (!update_i.load && $stable(timer_value_i)
      && $stable(compare_scale_select_i)) |-> $stable(timer_ge_flag_o))
    else $error("flag stepped as the threshold moved from the bus to the held copy");

  // each signed setting drives the flag from bit setting plus nine
  for (genvar s = 0; s < SEL_COUNT - 1; s++) begin : g_scale_chk
    scale_bit_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE6
      (compare_scale_select_i == 4'(s)) |-> timer_ge_flag_o == wrap_diff[s + SIGNED_BASE])
      else $error("signed setting did not drive the flag from its own result bit");
  end

  // flag holds while timer, scale and threshold all hold
  flag_steady_a : assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE2
    ($stable(timer_value_i) && $stable(compare_scale_select_i) && $stable(live_threshold))
      |-> $stable(timer_ge_flag_o))
    else $error("flag moved with no change of timer, scale or threshold");

endmodule

`default_nettype wire

// >>> tb/capture_cell_model.sv
// capture cell model that hands thresholds to the comparator
`timescale 1ns/10ps
`default_nettype none
module capture_cell_model (
  output var ge_compare_pkg::compare_update_s update_o
);
  import ge_compare_pkg::*;
  initial update_o = '{load: 1'b0, value: 24'h00_0000};
  // raise load with the new threshold; it stays up until the next idle call
  task automatic send(input logic [23:0] thr);
    update_o = '{load: 1'b1, value: thr};
  endtask
  // released bus value flips on each idle call so stale data never looks valid
  task automatic idle();
    update_o = '{load: 1'b0, value: ~update_o.value};
  endtask
endmodule
`default_nettype wire

// >>> tb/scalable_signed_ge_comparator_tb.sv
// self-checking bench for the scalable greater-or-equal comparator
`timescale 1ns/10ps
`default_nettype none
module scalable_signed_ge_comparator_tb;
  import ge_compare_pkg::*;
  logic            clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic [23:0]     timer_value_i = 24'h00_0000;
  logic [3:0]      compare_scale_select_i = 4'hf;
  compare_update_s update_i;
  logic            timer_ge_flag_o;
  int              num_errors = 0;
  int              n_tests = 0;
  capture_cell_model u_cell (.update_o(update_i));
  scalable_ge_comparator u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .timer_value_i(timer_value_i),
    .update_i(update_i), .compare_scale_select_i(compare_scale_select_i),
    .timer_ge_flag_o(timer_ge_flag_o));
  // 25 MHz clock
  initial forever #20 clk_i = ~clk_i;
  task automatic check(input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // drive timer, scale and maybe a load, then judge the flag
  task automatic apply(input logic [23:0] t, input logic [3:0] s, input logic [23:0] th,
                       input logic ld);
    logic [24:0] d;
    @(negedge clk_i);
    if (ld) u_cell.send(th);
    else u_cell.idle();
    timer_value_i = t;
    compare_scale_select_i = s;
    d = {1'b0, t} - {1'b0, th};
    #2 check(timer_ge_flag_o, (s == SCALE_UNSIGNED) ? d[24] : d[s + 9]);
  endtask
  // unsigned: below, equal, top and bottom of the range
  task automatic unsigned_mode();
    apply(24'h3f_ffff, SCALE_UNSIGNED, 24'h40_0000, 1'b1);
    apply(24'h40_0000, SCALE_UNSIGNED, 24'h40_0000, 1'b0);
    apply(24'hff_ffff, SCALE_UNSIGNED, 24'h40_0000, 1'b0);
    apply(24'h00_0000, SCALE_UNSIGNED, 24'h40_0000, 1'b0);
  endtask
  // signed: every scale, window edges around a low threshold
  task automatic signed_mode();
    logic [23:0] w;
    for (int s = 0; s < 15; s++) begin
      w = 24'h00_0200 << s;
      apply(24'h00_0100, 4'(s), 24'h00_0100, 1'b1);
      apply(24'h00_00ff + w, 4'(s), 24'h00_0100, 1'b0);
      apply(24'h00_0100 + w, 4'(s), 24'h00_0100, 1'b0);
      apply(24'h00_0100 - w, 4'(s), 24'h00_0100, 1'b0);
    end
  endtask
  // threshold counts in its load cycle; loads back to back
  task automatic bypass();
    apply(24'h00_1000, SCALE_UNSIGNED, 24'h00_2000, 1'b1);
    apply(24'h00_1000, SCALE_UNSIGNED, 24'h00_0800, 1'b1);
    apply(24'h00_1000, SCALE_UNSIGNED, 24'h00_0800, 1'b0);
    apply(24'h00_07ff, SCALE_UNSIGNED, 24'h00_0800, 1'b0);
  endtask
  // reset in mid-run: held threshold back to zero, flag After
  task automatic reset_midrun();
    apply(24'h00_0010, SCALE_UNSIGNED, 24'h80_0000, 1'b1);
    @(negedge clk_i);
    u_cell.idle();
    rst_n_i = 1'b0;
    #2 check(timer_ge_flag_o, 1'b0);
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    apply(24'h00_0010, SCALE_UNSIGNED, THRESHOLD_RST, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    unsigned_mode();
    signed_mode();
    bypass();
    reset_midrun();
    report_and_stop();
  end
  // watchdog of 2000 cycles
  initial begin
    #80000;
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
